// >>> tb/fpa_ctrl_asserts.sv
// Purpose: Pin-level checks on the fuse PROM controller
// Assumes: One clock domain, bound to fpa_ctrl
// Notes:   Sense-off and address-quiet counters saturate so long idles stay legal
`timescale 1ns/1ps
module fpa_ctrl_asserts #(
   parameter int MAX_PULSES = 4
) (
   // Clock and reset
   input wire logic                       sys_clk,
   input wire logic                       rst_n,
   // Request side
   input wire logic                       reqValid,
   input wire logic                       reqProgram,
   input wire logic                       reqReady,
   input wire logic                       rspValid,
   input wire logic [fpa_pkg::ADDR_W-1:0] reqAddr,
   input wire logic [2:0]                 reqBit,
   // PROM side
   input wire logic [fpa_pkg::ADDR_W-1:0] word_select_inputs,
   input wire logic [2:0]                 chip_select_lines,
   input wire logic [fpa_pkg::DATA_W-1:0] pulseOn,
   input wire logic [fpa_pkg::DATA_W-1:0] senseOn
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   logic [7:0] senseOffCnt;
   logic [7:0] addrQuietCnt;
   logic [7:0] hiCnt;
   logic [2:0] bitHeld;
   wire        take = reqValid && reqReady;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         senseOffCnt  <= 8'hff;
         addrQuietCnt <= 8'hff;
         hiCnt        <= 8'h00;
         bitHeld      <= 3'h0;
      end else begin
         senseOffCnt  <= (senseOn != 8'h00) ? 8'h00 : senseOffCnt + {7'h0, senseOffCnt != 8'hff};
         addrQuietCnt <= $changed(word_select_inputs) ? 8'h00
                         : addrQuietCnt + {7'h0, addrQuietCnt != 8'hff};
         hiCnt        <= (pulseOn != 8'h00) ? hiCnt + 8'h01 : 8'h00;
         if (take && reqProgram)
            bitHeld <= reqBit;
      end
   end
   sequence readTake;
      take && !reqProgram;
   endsequence
   sequence readWalk;
      (chip_select_lines == 3'h6) [*4] ##1 (rspValid && chip_select_lines == 3'h7);
   endsequence
   AST_READ_WALK: assert property (readTake |=> readWalk)
      else $error("read did not enable then answer in five cycles");
   AST_ADDR_SET: assert property (take |=> word_select_inputs == $past(reqAddr))
      else $error("address pins differ from taken address");
   AST_PULSE_DIS: assert property (pulseOn != 8'h00 |-> chip_select_lines == 3'h7)
      else $error("programming pulse while chip enabled");
   AST_SENSE_DIS: assert property (senseOn != 8'h00 |-> chip_select_lines == 3'h7)
      else $error("sense current while chip enabled");
   AST_DRIVE_BIT: assert property ((pulseOn | senseOn) != 8'h00
      |-> (pulseOn | senseOn) == (8'h01 << bitHeld))
      else $error("drive not on the requested output alone");
   AST_PULSE_WIDTH: assert property ($fell(pulseOn != 8'h00) |-> hiCnt inside {[72:78]})
      else $error("pulse width outside 7.5 us tolerance");
   AST_QUIET_BEFORE: assert property ($changed(word_select_inputs)
      |-> senseOffCnt >= fpa_pkg::ADDR_QUIET_CYC)
      else $error("address changed too soon after sense");
   AST_QUIET_AFTER: assert property (senseOn != 8'h00
      |-> addrQuietCnt >= fpa_pkg::ADDR_QUIET_CYC - 1)
      else $error("sense applied too soon after address change");
endmodule // fpa_ctrl_asserts

bind fpa_ctrl fpa_ctrl_asserts #(.MAX_PULSES(MAX_PULSES)) fpa_ctrl_asserts_inst (
   .sys_clk(sys_clk), .rst_n(rst_n), .reqValid(reqValid), .reqProgram(reqProgram),
   .reqReady(reqReady), .rspValid(rspValid), .reqAddr(reqAddr), .reqBit(reqBit),
   .word_select_inputs(word_select_inputs), .chip_select_lines(chip_select_lines),
   .pulseOn(pulseOn), .senseOn(senseOn));

// >>> tb/fpa_prom_model.sv
// Purpose: Behavioural fuse PROM seen from its pins
// Assumes: Fuse blows after BLOW_PULSES pulses; STUCK_ADDR never blows
// Notes:   Floating outputs read high, as with a pull-up
`timescale 1ns/1ps
module fpa_prom_model #(
   parameter int          BLOW_PULSES = 2,
   parameter logic [10:0] STUCK_ADDR  = 11'h7ff
) (
   // Pins driven by the controller
   input wire logic [10:0] word_select_inputs,
   input wire logic [2:0]  chip_select_lines,
   input wire logic [7:0]  pulseOn,
   input wire logic [7:0]  senseOn,
   // Pins back to the controller
   output logic [7:0]      data_output_lines,
   output logic            senseOk
);
   logic [7:0] fuse [2048];
   logic [7:0] prevPulse;
   int         hits [8];
   wire        enabled = chip_select_lines == 3'h6;
   initial begin
      foreach (fuse[i]) fuse[i] = 8'h00;
      prevPulse = 8'h00;
   end
   // Count restarts per word: one address path for read and program
   always @(word_select_inputs) foreach (hits[b]) hits[b] = 0;
   always @(pulseOn) begin
      foreach (hits[b])
         if (pulseOn[b] && !prevPulse[b] && !enabled) begin
            hits[b]++;
            if (hits[b] >= BLOW_PULSES && word_select_inputs != STUCK_ADDR)
               fuse[word_select_inputs][b] = 1'b1;
         end
      prevPulse = pulseOn;
   end
   assign data_output_lines = enabled ? fuse[word_select_inputs] : 8'hff;
   assign senseOk = !enabled && senseOn != 8'h00
                    && (fuse[word_select_inputs] & senseOn) != 8'h00;
endmodule // fpa_prom_model

// >>> tb/test_fpa_ctrl.sv
// Purpose: Self-checking bench for the fuse PROM controller
// Assumes: Model blows a fuse on the second pulse
// Notes:   MAX_PULSES kept small so the give-up path is short
`timescale 1ns/1ps
module test_fpa_ctrl;
   localparam logic [10:0] STUCK = 11'h2aa;
   logic        sys_clk, rst_n, reqValid, reqProgram, reqReady, rspValid, rspFail, senseOk;
   logic        gotFail, pulsePrev;
   logic [10:0] reqAddr, wsel;
   logic [2:0]  reqBit, csel;
   logic [7:0]  rspData, dout, pulseOn, senseOn, gotData;
   int          badCount, checksDone, pulseCount;
   fpa_ctrl #(.MAX_PULSES(4)) fpa_ctrl_inst (.sys_clk(sys_clk), .rst_n(rst_n),
      .reqValid(reqValid), .reqProgram(reqProgram), .reqAddr(reqAddr), .reqBit(reqBit),
      .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData), .rspFail(rspFail),
      .word_select_inputs(wsel), .chip_select_lines(csel), .data_output_lines(dout),
      .pulseOn(pulseOn), .senseOn(senseOn), .senseOk(senseOk));
   fpa_prom_model #(.BLOW_PULSES(2), .STUCK_ADDR(STUCK)) fpa_prom_model_inst (
      .word_select_inputs(wsel), .chip_select_lines(csel), .pulseOn(pulseOn),
      .senseOn(senseOn), .data_output_lines(dout), .senseOk(senseOk));
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      if (pulseOn != 8'h00 && !pulsePrev) pulseCount++;
      pulsePrev <= pulseOn != 8'h00;
   end
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checksDone++;
      if (seen !== exp) begin
         badCount++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic request(input logic prog, input logic [10:0] addr, input logic [2:0] bitIdx);
      int n;
      reqValid <= 1'b1;
      reqProgram <= prog;
      reqAddr <= addr;
      reqBit <= bitIdx;
      @(posedge sys_clk);
      reqValid <= 1'b0;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
         if (n == 1)
            check("busy after take", {15'h0, reqReady}, 16'h0);
      end while (rspValid !== 1'b1 && n < 3000);
      check("rspValid", {15'h0, rspValid}, 16'h1);
      gotData = rspData;
      gotFail = rspFail;
   endtask
   task automatic test_reset;
      check("chip select idle", {13'h0, csel}, 16'h7);
      check("pulse idle", {8'h0, pulseOn | senseOn}, 16'h0);
   endtask
   task automatic test_blank;
      request(1'b0, 11'h000, 3'h0);
      check("blank low", {8'h0, gotData}, 16'h0);
      request(1'b0, 11'h7ff, 3'h0);
      check("blank top", {8'h0, gotData}, 16'h0);
   endtask
   task automatic test_program;
      pulseCount = 0;
      request(1'b1, 11'h005, 3'h3);
      check("prog fail flag", {15'h0, gotFail}, 16'h0);
      check("pulse count", pulseCount[15:0], 16'h6);
      request(1'b1, 11'h005, 3'h7);
      request(1'b0, 11'h005, 3'h0);
      check("word 5", {8'h0, gotData}, 16'h0088);
      request(1'b0, 11'h004, 3'h0);
      check("word 4", {8'h0, gotData}, 16'h0);
   endtask
   task automatic test_stuck;
      pulseCount = 0;
      request(1'b1, STUCK, 3'h0);
      check("give up flag", {15'h0, gotFail}, 16'h1);
      // Bench runs the controller with a cap of four pulses
      check("give up pulses", pulseCount[15:0], 16'h4);
      request(1'b0, STUCK, 3'h0);
      check("stuck word", {8'h0, gotData}, 16'h0);
   endtask
   task automatic reportAndStop;
      $display("comparisons %0d mismatches %0d", checksDone, badCount);
      if (badCount == 0 && checksDone > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      rst_n = 1'b0;
      reqValid = 1'b0;
      reqProgram = 1'b0;
      reqAddr = 11'h000;
      reqBit = 3'h0;
      pulsePrev = 1'b0;
      badCount = 0;
      checksDone = 0;
      pulseCount = 0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      test_reset();
      test_blank();
      test_program();
      test_stuck();
      reportAndStop();
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      badCount++;
      reportAndStop();
   end
endmodule // test_fpa_ctrl

// >>> verilog/fpa_ctrl.sv
// Purpose: Host controller that reads and programs a 2K x 8 fuse PROM through its pins
// Assumes: Analog pulse/sense drivers outside; senseOk pin is high when the sensed
//          voltage passes the limit. sys_clk 10 MHz.
// Notes:   Reads and programs are one request each; one bit programmed per request.
// Functional notes
// - One address bus selects the word both for reading and for programming.
// - The chip is enabled only with select line 1 low and select lines 2 and 3 high.
// - Programming stimuli are applied only while a select line keeps the outputs disabled.
// - To program, disable the chip, set the address, then pulse the output of the bit.
// - Each pulse lasts about 7.5 us and the pulse train keeps at least 70 percent duty; a pulse after any second reading follows the 10 us verify gap.
// - Sensing waits at least 0.7 us after each pulse's trailing edge.
// - A bit passes after two sense readings 10 us apart with no pulse between both pass.
// - After passing, four extra pulses are applied and the sense current is removed.
// - Sense current is off for at least 10 us before and after every address change.
`timescale 1ns/1ps
module fpa_ctrl #(
   parameter int MAX_PULSES = fpa_pkg::MAX_PULSES_DEF
) (
   // Clock and reset
   input  wire logic                       sys_clk,
   input  wire logic                       rst_n,
   // Request port
   input  wire logic                       reqValid,
   input  wire logic                       reqProgram,
   input  wire logic [fpa_pkg::ADDR_W-1:0] reqAddr,
   input  wire logic [2:0]                 reqBit,
   output logic                            reqReady,
   output logic                            rspValid,
   output logic [fpa_pkg::DATA_W-1:0]      rspData,
   output logic                            rspFail,
   // PROM pins
   output logic [fpa_pkg::ADDR_W-1:0]      word_select_inputs,
   output logic [2:0]                      chip_select_lines,
   input  wire logic [fpa_pkg::DATA_W-1:0] data_output_lines,
   // Programmer drive
   output logic [fpa_pkg::DATA_W-1:0]      pulseOn,
   output logic [fpa_pkg::DATA_W-1:0]      senseOn,
   input  wire logic                       senseOk
);
   typedef enum {
      S_IDLE, S_RD_WAIT, S_QUIET_PRE, S_PULSE, S_SETTLE, S_SENSE1, S_GAP, S_SENSE2,
      S_EXTRA_PULSE, S_EXTRA_GAP, S_QUIET_POST
   } fpa_state_t;

   localparam int TW = 16;

   fpa_state_t                   state_ff, nxt_state;
   logic [TW-1:0]                timer_ff, nxt_timer;
   logic [fpa_pkg::CNT_W-1:0]    pulses_ff, nxt_pulses;
   logic [fpa_pkg::ADDR_W-1:0]   addr_ff, nxt_addr;
   logic [2:0]                   bit_ff, nxt_bit;
   logic [2:0]                   cs_ff, nxt_cs;
   logic                         pulse_ff, nxt_pulse;
   logic                         sense_ff, nxt_sense;
   logic                         rspValid_ff, nxt_rspValid;
   logic                         rspFail_ff, nxt_rspFail;
   logic [fpa_pkg::DATA_W-1:0]   rspData_ff, nxt_rspData;
   logic [fpa_pkg::DATA_W-1:0]   dataSync;
   logic                         okSync;

   fpa_sync2 #(.W(fpa_pkg::DATA_W + 1)) fpa_sync2_inst (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .asyncIn ({senseOk, data_output_lines}),
      .syncOut ({okSync, dataSync})
   );

   // Enabled = {sel3,sel2,sel1} = 3'b110; disabled holds sel1 high
   localparam logic [2:0] CS_ENABLE  = 3'h6;
   localparam logic [2:0] CS_DISABLE = 3'h7;

   always_comb begin
      nxt_state    = state_ff;
      nxt_timer    = (timer_ff != '0) ? timer_ff - TW'(1) : timer_ff;
      nxt_pulses   = pulses_ff;
      nxt_addr     = addr_ff;
      nxt_bit      = bit_ff;
      nxt_cs       = cs_ff;
      nxt_pulse    = 1'b0;
      nxt_sense    = sense_ff;
      nxt_rspValid = 1'b0;
      nxt_rspFail  = rspFail_ff;
      nxt_rspData  = rspData_ff;
      case (state_ff)
         S_IDLE: begin
            if (reqValid) begin
               nxt_addr = reqAddr;
               nxt_bit  = reqBit;
               if (reqProgram) begin
                  nxt_cs    = CS_DISABLE;
                  nxt_timer = TW'(fpa_pkg::ADDR_QUIET_CYC);
                  nxt_state = S_QUIET_PRE;
               end else begin
                  nxt_cs    = CS_ENABLE;
                  nxt_timer = TW'(fpa_pkg::RD_WAIT_CYC);
                  nxt_state = S_RD_WAIT;
               end
            end
         end
         S_RD_WAIT: begin
            // Sync delay covers access time; data captured after two flops
            if (timer_ff == '0) begin
               nxt_rspData  = dataSync;
               nxt_rspFail  = 1'b0;
               nxt_rspValid = 1'b1;
               nxt_cs       = CS_DISABLE;
               nxt_state    = S_IDLE;
            end
         end
         S_QUIET_PRE: begin
            if (timer_ff == '0) begin
               nxt_pulses = '0;
               nxt_sense  = 1'b1;
               nxt_pulse  = 1'b1;
               nxt_timer  = TW'(fpa_pkg::PULSE_CYC - 1);
               nxt_state  = S_PULSE;
            end
         end
         S_PULSE: begin
            nxt_pulse = 1'b1;
            if (timer_ff == '0) begin
               nxt_pulse  = 1'b0;
               nxt_pulses = pulses_ff + fpa_pkg::CNT_W'(1);
               // Settle plus sync latency, within the duty gap
               nxt_timer  = TW'(fpa_pkg::SENSE_DLY_CYC + 2);
               nxt_state  = S_SETTLE;
            end
         end
         S_SETTLE: begin
            if (timer_ff == '0) nxt_state = S_SENSE1;
         end
         S_SENSE1: begin
            if (okSync) begin
               nxt_timer = TW'(fpa_pkg::VERIFY_GAP_CYC - 1);
               nxt_state = S_GAP;
            end else if (pulses_ff >= fpa_pkg::CNT_W'(MAX_PULSES)) begin
               nxt_rspFail = 1'b1;
               nxt_sense   = 1'b0;
               nxt_timer   = TW'(fpa_pkg::ADDR_QUIET_CYC);
               nxt_state   = S_QUIET_POST;
            end else begin
               nxt_pulse = 1'b1;
               nxt_timer = TW'(fpa_pkg::PULSE_CYC - 1);
               nxt_state = S_PULSE;
            end
         end
         S_GAP: begin
            // No pulse between the two readings
            if (timer_ff == '0) nxt_state = S_SENSE2;
         end
         S_SENSE2: begin
            if (okSync) begin
               nxt_pulses = '0;
               nxt_pulse  = 1'b1;
               nxt_timer  = TW'(fpa_pkg::PULSE_CYC - 1);
               nxt_state  = S_EXTRA_PULSE;
            end else begin
               nxt_pulse = 1'b1;
               nxt_timer = TW'(fpa_pkg::PULSE_CYC - 1);
               nxt_state = S_PULSE;
            end
         end
         S_EXTRA_PULSE: begin
            nxt_pulse = 1'b1;
            if (timer_ff == '0) begin
               nxt_pulse  = 1'b0;
               nxt_pulses = pulses_ff + fpa_pkg::CNT_W'(1);
               nxt_timer  = TW'(fpa_pkg::SENSE_DLY_CYC);
               nxt_state  = S_EXTRA_GAP;
            end
         end
         S_EXTRA_GAP: begin
            if (timer_ff == '0) begin
               if (pulses_ff == fpa_pkg::CNT_W'(fpa_pkg::EXTRA_PULSES)) begin
                  nxt_sense   = 1'b0;
                  nxt_rspFail = 1'b0;
                  nxt_timer   = TW'(fpa_pkg::ADDR_QUIET_CYC);
                  nxt_state   = S_QUIET_POST;
               end else begin
                  nxt_pulse = 1'b1;
                  nxt_timer = TW'(fpa_pkg::PULSE_CYC - 1);
                  nxt_state = S_EXTRA_PULSE;
               end
            end
         end
         S_QUIET_POST: begin
            // Address held with sense off before release
            if (timer_ff == '0) begin
               nxt_rspData  = '0;
               nxt_rspValid = 1'b1;
               nxt_state    = S_IDLE;
            end
         end
         default: nxt_state = S_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff    <= S_IDLE;
         timer_ff    <= '0;
         pulses_ff   <= '0;
         addr_ff     <= '0;
         bit_ff      <= '0;
         cs_ff       <= CS_DISABLE;
         pulse_ff    <= 1'b0;
         sense_ff    <= 1'b0;
         rspValid_ff <= 1'b0;
         rspFail_ff  <= 1'b0;
         rspData_ff  <= '0;
      end else begin
         state_ff    <= nxt_state;
         timer_ff    <= nxt_timer;
         pulses_ff   <= nxt_pulses;
         addr_ff     <= nxt_addr;
         bit_ff      <= nxt_bit;
         cs_ff       <= nxt_cs;
         pulse_ff    <= nxt_pulse;
         sense_ff    <= nxt_sense;
         rspValid_ff <= nxt_rspValid;
         rspFail_ff  <= nxt_rspFail;
         rspData_ff  <= nxt_rspData;
      end
   end

   // Drive only the chosen bit's output; gated so nothing reaches an enabled chip
   assign pulseOn  = (pulse_ff && cs_ff != CS_ENABLE) ? (8'h01 << bit_ff) : 8'h00;
   assign senseOn  = (sense_ff && cs_ff != CS_ENABLE) ? (8'h01 << bit_ff) : 8'h00;
   assign word_select_inputs = addr_ff;
   assign chip_select_lines  = cs_ff;
   assign reqReady = (state_ff == S_IDLE);
   assign rspValid = rspValid_ff;
   assign rspData  = rspData_ff;
   assign rspFail  = rspFail_ff;
endmodule // fpa_ctrl

// >>> verilog/fpa_pkg.sv
// Purpose: Shared constants for the fuse PROM access controller
// Assumes: sys_clk at 10 MHz (100 ns period)
// Notes:   Times kept in ns; cycle counts derived from them, except RD_WAIT_CYC which is set directly
package fpa_pkg;
   localparam int CLK_PERIOD_NS = 100;
   localparam int ADDR_W        = 11;
   localparam int DATA_W        = 8;
   localparam int WORD_COUNT    = 2048;
   // Pulse width nominal 7.5 us; longest form rounds down
   localparam int PULSE_NS      = 7500;
   localparam int PULSE_CYC     = PULSE_NS / CLK_PERIOD_NS;
   // Duty cycle at least 70 percent: gap at most 30/70 of pulse
   localparam int DUTY_MIN_PCT  = 70;
   localparam int GAP_MAX_CYC   = (PULSE_CYC * (100 - DUTY_MIN_PCT)) / DUTY_MIN_PCT;
   // Sense delay after pulse trailing edge, least time rounds up
   localparam int SENSE_DLY_NS  = 700;
   localparam int SENSE_DLY_CYC = (SENSE_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int VERIFY_GAP_NS = 10000;
   localparam int VERIFY_GAP_CYC = (VERIFY_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ADDR_QUIET_NS = 10000;
   localparam int ADDR_QUIET_CYC = (ADDR_QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int EXTRA_PULSES  = 4;
   // Read wait before the two sync flops deliver the word
   localparam int RD_WAIT_CYC   = 3;
   localparam int MAX_PULSES_DEF = 100;
   localparam int CNT_W         = 8;
endpackage : fpa_pkg

// >>> verilog/fpa_sync2.sv
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Input is asynchronous to sys_clk
// Notes:   First stage is read by the second stage only
`timescale 1ns/1ps
module fpa_sync2 #(
   parameter int W = 8
) (
   // Clock and reset
   input  wire logic         sys_clk,
   input  wire logic         rst_n,
   // Data
   input  wire logic [W-1:0] asyncIn,
   output logic      [W-1:0] syncOut
);
   logic [W-1:0] stage1_ff;
   logic [W-1:0] stage2_ff;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1_ff <= '0;
         stage2_ff <= '0;
      end else begin
         stage1_ff <= asyncIn;
         stage2_ff <= stage1_ff;
      end
   end

   assign syncOut = stage2_ff;
endmodule // fpa_sync2
